// ---- drive_protection_restart_consts.vh ----
/*
 * Constants for the drive protection and restart supervisor: register
 * offsets, field positions, reset values, setting ranges and timing.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef DRIVE_PROTECTION_RESTART_CONSTS_VH
`define DRIVE_PROTECTION_RESTART_CONSTS_VH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_CAP         8'h04
`define OFS_THERMAL     8'h08
`define OFS_SKIP        8'h0C
`define OFS_RESTART     8'h10
`define OFS_STATUS      8'h14
`define OFS_HEAT        8'h18

// Control bits
`define CTRL_REVERSE    0
`define CTRL_FOLLOW     1
`define CTRL_FREEWHEEL  2
`define CTRL_PWRCLR     3
`define CTRL_TRIPCLR    4

// Reset values
`define RST_CAP         8'h7D
`define RST_UPPER       8'h64
`define RST_ZERO        8'h12
`define RST_CORNER      8'h32
`define RST_LIMIT       4'h0
`define RST_CLR_TIME    11'h4B0

// Setting ranges
`define CAP_MIN         8'h16
`define CAP_MAX         8'h7D
`define THR_MIN         8'h12
`define THR_MAX         8'h64
`define CORNER_MIN      8'h02
`define CORNER_MAX      8'hC8
`define FREQ_MAX        8'hC8
`define CLR_TIME_MIN    11'h001
`define CLR_TIME_MAX    11'h4B0
`define CLR_TIME_INF    11'h006

// Timing
`define CLK_HZ          20000000
`define TICK_MS         100
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define TICKS_PER_S     (1000 / `TICK_MS)
`define RESTART_WAIT_S  10
`define RESTART_TICKS   (`RESTART_WAIT_S * `TICKS_PER_S)
// 110 % for two minutes: (1.21-1)*120 s = 25.2 thr^2 seconds
`define HEAT_SCALE      252

`endif

// ---- drive_protection_restart.v ----
/*
 * Protection and stop/restart supervisor of an AC motor drive, with an
 * AHB-Lite register slave. Assumes currents in percent of rating and
 * frequencies in whole Hz, all inputs synchronous to clk.
 */
// What this block does
// - Cap output current at a 22..125 % setting; request speed reduction while over.
// - Integrate heating; trip when over limit, about two minutes at 110 %.
// - Heating grows with excess current, so bigger overloads trip sooner.
// - Upper thermal threshold 18..100 %; trip only after sustained excess.
// - Separate zero-speed threshold; refuse settings above the upper threshold.
// - Upper threshold above corner frequency 2..200 Hz; sloped profile below.
// - Reverse disabled at reset; reversal only when enabled.
// - Ramp may cross the skip band but settles inside it only when the band reaches past 255 Hz (target held at 255).
// - Skip band given by centre 0..200 Hz and half-width 0..200 Hz.
// - Normal mode forces M1,M2,M3 order; supply mode follows detected order.
// - Coast stop removes voltage at once; otherwise ramp down to rest.
// - After a trip wait 10 s, try clearing, retry every 10 s.
// - Restart attempts limited to 0..15; zero disables auto restart.
// - Trip-free running for clear time 1..1200 s restores full attempts.
// - Any non-automatic trip clear resets the attempt count.
// - Clear time of 6 s gives unlimited restarts.
// - Restart settings locked while essential services override is active.
// - With power-cycle clear enabled, a brief power loss clears trips.
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_restart_consts.vh"

module drive_protection_restart #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Measurements and commands
  input  wire [7:0]  current_pct,
  input  wire [7:0]  out_freq_hz,
  input  wire [7:0]  target_hz,
  input  wire        run_cmd,
  input  wire        reverse_request,
  input  wire        supply_reversed,
  input  wire        ext_trip,
  input  wire        fault_present,
  input  wire        power_restored,
  input  wire        essential_services_override,
  // Drive controls
  output reg  [7:0]  freq_target_hz,
  output reg         cap_active,
  output reg         drive_on,
  output reg         ramp_down,
  output reg         dir_reverse,
  output reg         phase_swap,
  output reg         trip,
  output reg         thermal_trip
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;
  // Settings
  reg        reverse_allow;
  reg        follow_input_phase_order;
  reg        freewheel_stop_enable;
  reg        power_cycle_trip_clear;
  reg [7:0]  output_current_cap;
  reg [7:0]  thermal_upper_threshold;
  reg [7:0]  thermal_zero_speed_threshold;
  reg [7:0]  thermal_corner_frequency;
  reg [7:0]  skip_band_centre;
  reg [7:0]  skip_band_half_width;
  reg [3:0]  restart_attempt_limit;
  reg [10:0] restart_count_clear_time;
  // AHB data phase
  reg        wr_pend;
  reg [7:0]  wr_addr;
  wire       addr_ok = hsel & hready & htrans[1];
  // Tick divider
  reg [31:0] tick_cnt;
  reg        tick;
  // Supervisor state
  reg [2:0]  state;
  reg [6:0]  wait_cnt;
  reg [3:0]  attempts_used;
  reg [14:0] run_cnt;
  reg        run_armed;
  reg        run_cmd_d;
  reg        manual_clear;
  reg [25:0] heat;
  reg [7:0]  thr;
  // Serial divider for the threshold slope
  reg        div_busy;
  reg [15:0] div_rem;
  reg [7:0]  div_q;
  wire [31:0] wd = hwdata;
  wire [7:0]  new_upper = wd[7:0];
  wire [7:0]  new_zero = wd[15:8];
  wire [7:0]  new_corner = wd[23:16];
  wire [10:0] new_clr = wd[26:16];
  wire        thermal_ok = (new_upper >= `THR_MIN) && (new_upper <= `THR_MAX) &&
                           (new_zero >= `THR_MIN) && (new_zero <= new_upper) &&
                           (new_corner >= `CORNER_MIN) && (new_corner <= `CORNER_MAX);
  wire        wr_ctrl = wr_pend && (wr_addr == `OFS_CTRL);
  // Tick every TICK_CYCLES clocks
  always @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
  // Register writes; out-of-range values are dropped, old value kept
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      reverse_allow <= 1'b0;
      follow_input_phase_order <= 1'b0;
      freewheel_stop_enable <= 1'b0;
      power_cycle_trip_clear <= 1'b0;
      output_current_cap <= `RST_CAP;
      thermal_upper_threshold <= `RST_UPPER;
      thermal_zero_speed_threshold <= `RST_ZERO;
      thermal_corner_frequency <= `RST_CORNER;
      skip_band_centre <= 8'h00;
      skip_band_half_width <= 8'h00;
      restart_attempt_limit <= `RST_LIMIT;
      restart_count_clear_time <= `RST_CLR_TIME;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr;
      if (wr_pend) begin
        case (wr_addr)
          `OFS_CTRL: begin
            reverse_allow <= wd[`CTRL_REVERSE];
            follow_input_phase_order <= wd[`CTRL_FOLLOW];
            freewheel_stop_enable <= wd[`CTRL_FREEWHEEL];
            power_cycle_trip_clear <= wd[`CTRL_PWRCLR];
          end
          `OFS_CAP: begin
            if (wd[7:0] >= `CAP_MIN && wd[7:0] <= `CAP_MAX)
              output_current_cap <= wd[7:0];
          end
          `OFS_THERMAL: begin
            if (thermal_ok) begin
              thermal_upper_threshold <= new_upper;
              thermal_zero_speed_threshold <= new_zero;
              thermal_corner_frequency <= new_corner;
            end
          end
          `OFS_SKIP: begin
            if (wd[7:0] <= `FREQ_MAX && wd[15:8] <= `FREQ_MAX) begin
              skip_band_centre <= wd[7:0];
              skip_band_half_width <= wd[15:8];
            end
          end
          `OFS_RESTART: begin
            // Locked under override so a fire pump keeps its retries
            if (!essential_services_override &&
                new_clr >= `CLR_TIME_MIN && new_clr <= `CLR_TIME_MAX) begin
              restart_attempt_limit <= wd[3:0];
              restart_count_clear_time <= new_clr;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // Bus answers: zero wait state, always OKAY, unmapped reads zero
  always @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        case (haddr)
          `OFS_CTRL:
            hrdata <= {28'h0000000, power_cycle_trip_clear, freewheel_stop_enable,
                       follow_input_phase_order, reverse_allow};
          `OFS_CAP:
            hrdata <= {24'h000000, output_current_cap};
          `OFS_THERMAL:
            hrdata <= {8'h00, thermal_corner_frequency,
                       thermal_zero_speed_threshold, thermal_upper_threshold};
          `OFS_SKIP:
            hrdata <= {16'h0000, skip_band_half_width, skip_band_centre};
          `OFS_RESTART:
            hrdata <= {5'h00, restart_count_clear_time, 12'h000, restart_attempt_limit};
          `OFS_STATUS:
            hrdata <= {8'h00, thr, 4'h0, attempts_used, state,
                       ramp_down, drive_on, cap_active, thermal_trip, trip};
          `OFS_HEAT:
            hrdata <= {6'h00, heat};
          default:
            hrdata <= 32'h00000000;
        endcase
      end
    end
  end
  // Threshold profile, recomputed continuously by repeated subtraction
  wire [7:0]  thr_span = thermal_upper_threshold - thermal_zero_speed_threshold;
  wire [15:0] slope_num = thr_span * out_freq_hz;
  always @(posedge clk) begin
    if (!rst_n) begin
      div_busy <= 1'b0;
      div_rem <= 16'h0000;
      div_q <= 8'h00;
      thr <= `RST_UPPER;
    end else if (!div_busy) begin
      if (out_freq_hz >= thermal_corner_frequency)
        thr <= thermal_upper_threshold;
      else begin
        div_busy <= 1'b1;
        div_rem <= slope_num;
        div_q <= 8'h00;
      end
    end else if (div_rem >= {8'h00, thermal_corner_frequency}) begin
      div_rem <= div_rem - {8'h00, thermal_corner_frequency};
      div_q <= div_q + 8'h01;
    end else begin
      div_busy <= 1'b0;
      thr <= thermal_zero_speed_threshold + div_q;
    end
  end
  // Heating estimate in (percent)^2 x ticks
  wire [15:0] cur_sq = current_pct * current_pct;
  wire [15:0] thr_sq = thr * thr;
  // Worst case 10000 x 252 fits in 26 bits
  wire [31:0] heat_limit_full = thr_sq * `HEAT_SCALE;
  wire [25:0] heat_limit = heat_limit_full[25:0];
  wire        over = cur_sq > thr_sq;
  wire [25:0] heat_up = heat + {10'h000, cur_sq - thr_sq};
  wire [15:0] cool = thr_sq - cur_sq;
  wire        heat_trip = heat > heat_limit;
  always @(posedge clk) begin
    if (!rst_n)
      heat <= 26'h0000000;
    else if (tick) begin
      if (over)
        heat <= heat_up;
      else if (heat > {10'h000, cool})
        heat <= heat - {10'h000, cool};
      else
        heat <= 26'h0000000;
    end
  end
  // Skip band: a target inside the band moves to its nearer edge
  wire [8:0] band_lo = {1'b0, skip_band_centre} - {1'b0, skip_band_half_width};
  wire [8:0] band_hi = {1'b0, skip_band_centre} + {1'b0, skip_band_half_width};
  wire       lo_valid = skip_band_centre >= skip_band_half_width;
  wire       in_band = (skip_band_half_width != 8'h00) &&
                       ({1'b0, target_hz} < band_hi) &&
                       (!lo_valid || {1'b0, target_hz} > band_lo);
  wire       use_lo = lo_valid && (target_hz < skip_band_centre);
  wire [7:0] hi_edge = band_hi[8] ? 8'hFF : band_hi[7:0];
  // Restart supervision
  wire infinite = restart_count_clear_time == `CLR_TIME_INF;
  wire attempts_left = infinite || (attempts_used < restart_attempt_limit);
  wire auto_on = restart_attempt_limit != 4'h0;
  wire trip_event = ext_trip | heat_trip;
  wire [31:0] clr_ticks_full = restart_count_clear_time * `TICKS_PER_S;
  wire [14:0] clr_ticks = clr_ticks_full[14:0];
  wire sw_clear = wr_ctrl && wd[`CTRL_TRIPCLR];
  wire pf_clear = power_cycle_trip_clear && power_restored;
  wire auto_clear = (state == ST_WAIT) && tick &&
                    (wait_cnt == `RESTART_TICKS - 1) && !fault_present;
  wire any_clear = sw_clear | pf_clear | auto_clear;
  always @(posedge clk) begin
    if (!rst_n) begin
      trip <= 1'b0;
      thermal_trip <= 1'b0;
      state <= ST_IDLE;
      wait_cnt <= 7'h00;
      attempts_used <= 4'h0;
      run_cnt <= 15'h0000;
      manual_clear <= 1'b0;
    end else begin
      manual_clear <= sw_clear | pf_clear;
      // A new trip in the clear cycle wins
      if (trip_event) begin
        trip <= 1'b1;
        thermal_trip <= thermal_trip | heat_trip;
      end else if (any_clear) begin
        trip <= 1'b0;
        thermal_trip <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          wait_cnt <= 7'h00;
          if (trip_event || trip)
            state <= (auto_on && attempts_left) ? ST_WAIT : ST_HALT;
        end
        ST_WAIT: begin
          if (tick) begin
            if (wait_cnt == `RESTART_TICKS - 1) begin
              wait_cnt <= 7'h00;
              if (!infinite)
                attempts_used <= attempts_used + 4'h1;
              if (!fault_present)
                state <= ST_IDLE;
              else if (!infinite && attempts_used + 4'h1 >= restart_attempt_limit)
                state <= ST_HALT;
            end else
              wait_cnt <= wait_cnt + 7'h01;
          end
          if (sw_clear || pf_clear)
            state <= ST_IDLE;
        end
        ST_HALT: begin
          if (sw_clear || pf_clear)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // Trip-free running restores the allowance
      if (trip || trip_event)
        run_cnt <= 15'h0000;
      else if (tick && drive_on) begin
        if (run_cnt >= clr_ticks - 15'h0001) begin
          run_cnt <= 15'h0000;
          attempts_used <= 4'h0;
        end else
          run_cnt <= run_cnt + 15'h0001;
      end
      if (manual_clear)
        attempts_used <= 4'h0;
    end
  end

  // Run, stop and direction outputs
  wire run_edge = run_cmd & ~run_cmd_d;
  wire stopping = run_armed & ~run_cmd;

  always @(posedge clk) begin
    if (!rst_n) begin
      run_cmd_d <= 1'b0;
      run_armed <= 1'b0;
      drive_on <= 1'b0;
      ramp_down <= 1'b0;
      cap_active <= 1'b0;
      dir_reverse <= 1'b0;
      phase_swap <= 1'b0;
      freq_target_hz <= 8'h00;
    end else begin
      run_cmd_d <= run_cmd;
      // A run held through a trip does not restart the motor
      if (trip || trip_event)
        run_armed <= 1'b0;
      else if (run_edge)
        run_armed <= 1'b1;
      else if (!run_cmd)
        run_armed <= 1'b0;
      if (trip || trip_event) begin
        drive_on <= 1'b0;
        ramp_down <= 1'b0;
      end else if (stopping) begin
        drive_on <= !freewheel_stop_enable && out_freq_hz != 8'h00;
        ramp_down <= !freewheel_stop_enable && out_freq_hz != 8'h00;
      end else if (ramp_down) begin
        drive_on <= out_freq_hz != 8'h00;
        ramp_down <= out_freq_hz != 8'h00;
        if (run_edge)
          ramp_down <= 1'b0;
      end else
        drive_on <= run_armed || (run_edge && !fault_present);
      cap_active <= current_pct > output_current_cap;
      dir_reverse <= reverse_request & reverse_allow;
      phase_swap <= follow_input_phase_order & supply_reversed;
      if (in_band)
        freq_target_hz <= use_lo ? band_lo[7:0] : hi_edge;
      else
        freq_target_hz <= target_hz;
    end
  end

endmodule
`default_nettype wire

// ---- drive_protection_restart_chk.sv ----
/*
 * Port-level checker for the drive protection supervisor.
 * Assumes it is bound to the design top and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_protection_restart_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Watched ports
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [7:0] current_pct,
  input wire logic [7:0] out_freq_hz,
  input wire logic       run_cmd,
  input wire logic       reverse_request,
  input wire logic       supply_reversed,
  input wire logic       ext_trip,
  input wire logic       cap_active,
  input wire logic       drive_on,
  input wire logic       ramp_down,
  input wire logic       dir_reverse,
  input wire logic       phase_swap,
  input wire logic       trip,
  input wire logic       thermal_trip
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_off;
    trip && !drive_on;
  endsequence
  sequence s_ramping;
    ramp_down && out_freq_hz != 8'h00 && !ext_trip && !trip;
  endsequence
  property p_bus;
    hreadyout && !hresp;
  endproperty
  property p_trip;
    ext_trip |=> s_off;
  endproperty
  property p_cap;
    current_pct > 8'h7D |=> cap_active;
  endproperty
  property p_dir;
    dir_reverse |-> $past(reverse_request);
  endproperty
  property p_phase;
    phase_swap |-> $past(supply_reversed);
  endproperty
  property p_ramp;
    s_ramping |=> drive_on;
  endproperty
  property p_start;
    $rose(drive_on) |-> $past(run_cmd);
  endproperty
  property p_thermal;
    thermal_trip |-> trip;
  endproperty
  a_bus:     assert property (p_bus) else $error("bus answer not ready or not okay");
  a_trip:    assert property (p_trip) else $error("trip not taken");
  a_cap:     assert property (p_cap) else $error("cap missing");
  a_dir:     assert property (p_dir) else $error("reverse without request");
  a_phase:   assert property (p_phase) else $error("swap without reversed supply");
  a_ramp:    assert property (p_ramp) else $error("drive off during ramp");
  a_start:   assert property (p_start) else $error("start without run");
  a_thermal: assert property (p_thermal) else $error("thermal flag alone");
endmodule
`default_nettype wire

// ---- drive_core_model.sv ----
/*
 * Motor core stand-in: moves output frequency one Hz a cycle.
 * Assumes the supervisor outputs are registered on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // From supervisor
  input  wire logic       drive_on,
  input  wire logic       ramp_down,
  input  wire logic       cap_active,
  input  wire logic [7:0] freq_target_hz,
  // To supervisor
  output var  logic [7:0] out_freq_hz
);
  wire run = drive_on && !ramp_down;
  always @(posedge clk) begin
    if (!rst_n)
      out_freq_hz <= 8'h00;
    else if (cap_active && out_freq_hz != 8'h00)
      out_freq_hz <= out_freq_hz - 8'h01;
    else if (run && out_freq_hz < freq_target_hz)
      out_freq_hz <= out_freq_hz + 8'h01;
    else if (run && out_freq_hz > freq_target_hz)
      out_freq_hz <= out_freq_hz - 8'h01;
    // Coast decays as fast as a ramp; keeps the run short
    else if (!run && out_freq_hz != 8'h00)
      out_freq_hz <= out_freq_hz - 8'h01;
  end
endmodule
`default_nettype wire

// ---- drive_protection_restart_bench.sv ----
/*
 * Self-checking bench for the drive protection supervisor.
 * Assumes the AHB-Lite slave answers with no wait states.
 */
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_restart_consts.vh"
module drive_protection_restart_bench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [7:0]  current_pct = 8'h00;
  reg  [7:0]  target_hz = 8'h00;
  reg         run_cmd = 1'b0, reverse_request = 1'b0, supply_reversed = 1'b0;
  reg         ext_trip = 1'b0, fault_present = 1'b0, power_restored = 1'b0;
  reg         essential_services_override = 1'b0;
  wire [31:0] hrdata;
  wire [7:0]  out_freq_hz, freq_target_hz;
  wire        hreadyout, hresp, cap_active, drive_on, ramp_down;
  wire        dir_reverse, phase_swap, trip, thermal_trip;
  integer     err_total = 0, checks = 0, cyc = 0, i, c;
  reg  [31:0] rnd = 32'h67A3F9DE, rv;

  drive_protection_restart #(.TICK_CYCLES(10)) u_dut (
    .clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .current_pct(current_pct), .out_freq_hz(out_freq_hz), .target_hz(target_hz),
    .run_cmd(run_cmd), .reverse_request(reverse_request),
    .supply_reversed(supply_reversed), .ext_trip(ext_trip),
    .fault_present(fault_present), .power_restored(power_restored),
    .essential_services_override(essential_services_override),
    .freq_target_hz(freq_target_hz), .cap_active(cap_active), .drive_on(drive_on),
    .ramp_down(ramp_down), .dir_reverse(dir_reverse), .phase_swap(phase_swap),
    .trip(trip), .thermal_trip(thermal_trip));
  drive_core_model u_core (
    .clk(clk), .rst_n(rst_n), .drive_on(drive_on), .ramp_down(ramp_down),
    .cap_active(cap_active), .freq_target_hz(freq_target_hz),
    .out_freq_hz(out_freq_hz));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] skp(input integer t, input integer c, input integer h);
    if (h != 0 && t > c - h && t < c + h)
      skp = (t < c && c >= h) ? c - h : (c + h > 255 ? 255 : c + h);
    else
      skp = t;
  endfunction
  function integer thr(input integer f, input integer u, input integer z, input integer k);
    thr = f >= k ? u : z + (u - z) * f / k;
  endfunction
  task tk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string n, input [31:0] e, input [31:0] s);
    checks = checks + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task ahb(input [7:0] a, input w, input [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    ahb(a, 1'b1, d);
  endtask
  task rc(input string n, input [7:0] a, input [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(n, e, rv);
  endtask
  task kick;
    @(posedge clk) ext_trip <= 1'b1;
    @(posedge clk) ext_trip <= 1'b0;
  endtask
  task wrap_up;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    tk(2);
    rst_n <= 1'b1;
    rc("ctrl", `OFS_CTRL, 32'h0);
    rc("cap", `OFS_CAP, 32'h7D);
    rc("thermal", `OFS_THERMAL, 32'h00321264);
    rc("skip", `OFS_SKIP, 32'h0);
    rc("restart", `OFS_RESTART, 32'h04B00000);
    rc("unmapped", 8'h1C, 32'h0);
    wr(`OFS_CAP, 32'h15);
    wr(`OFS_CAP, 32'h7E);
    rc("cap", `OFS_CAP, 32'h7D);
    wr(`OFS_THERMAL, 32'h00324140);
    wr(`OFS_THERMAL, 32'h00C91264);
    rc("thermal", `OFS_THERMAL, 32'h00321264);
    wr(`OFS_THERMAL, 32'h00282050);
    rc("thermal", `OFS_THERMAL, 32'h00282050);
    reverse_request <= 1'b1;
    supply_reversed <= 1'b1;
    for (c = 0; c < 4; c = c + 1) begin
      wr(`OFS_CTRL, c);
      tk(2);
      chk("dir", c[0], dir_reverse);
      chk("phase", c[1], phase_swap);
    end
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CAP, 32'h50);
    wr(`OFS_SKIP, 32'h051E);
    // Odd steps roam widely, even steps crowd the band edges
    for (i = 0; i < 24; i = i + 1) begin
      rnd = lfsr(rnd);
      // Kept under 144 % so the short loop cannot heat up to a trip
      current_pct <= rnd[23:16] & 8'h8F;
      target_hz <= i[0] ? {2'b00, rnd[13:8]} : 8'h18 + rnd[11:8];
      tk(3);
      chk("cap", current_pct > 8'h50, cap_active);
      chk("skip", skp(target_hz, 30, 5), freq_target_hz);
    end
    current_pct <= 8'h00;
    wr(`OFS_SKIP, 32'h0);
    target_hz <= 8'h14;
    run_cmd <= 1'b1;
    while (out_freq_hz !== 8'h14) @(posedge clk);
    tk(300);
    ahb(`OFS_STATUS, 1'b0, 32'h0);
    chk("thr", thr(20, 80, 32, 40), rv[23:16]);
    target_hz <= 8'h30;
    while (out_freq_hz !== 8'h30) @(posedge clk);
    tk(300);
    ahb(`OFS_STATUS, 1'b0, 32'h0);
    chk("thr", thr(48, 80, 32, 40), rv[23:16]);
    run_cmd <= 1'b0;
    tk(3);
    chk("ramp", 1, ramp_down);
    chk("on", 1, drive_on);
    while (out_freq_hz !== 8'h00) @(posedge clk);
    tk(3);
    chk("on", 0, drive_on);
    wr(`OFS_CTRL, 32'h4);
    run_cmd <= 1'b1;
    while (out_freq_hz !== 8'h30) @(posedge clk);
    run_cmd <= 1'b0;
    tk(2);
    chk("on", 0, drive_on);
    wr(`OFS_CAP, 32'h7D);
    wr(`OFS_THERMAL, 32'h00326464);
    // Let the new threshold settle before loading, else stray heat remains
    tk(5);
    current_pct <= 8'h64;
    tk(200);
    rc("heat", `OFS_HEAT, 32'h0);
    current_pct <= 8'h6E;
    tk(11900);
    chk("thermal", 0, thermal_trip);
    tk(300);
    chk("thermal", 1, thermal_trip);
    current_pct <= 8'h00;
    tk(100);
    wr(`OFS_CTRL, 32'h10);
    tk(3);
    chk("trip", 0, trip);
    wr(`OFS_RESTART, 32'h04B00001);
    fault_present <= 1'b1;
    kick;
    tk(900);
    chk("trip", 1, trip);
    tk(300);
    ahb(`OFS_STATUS, 1'b0, 32'h0);
    chk("state", 3'h4, rv[7:5]);
    chk("used", 1, rv[11:8]);
    wr(`OFS_CTRL, 32'h10);
    tk(3);
    ahb(`OFS_STATUS, 1'b0, 32'h0);
    chk("used", 0, rv[11:8]);
    fault_present <= 1'b0;
    wr(`OFS_RESTART, 32'h04B00002);
    run_cmd <= 1'b1;
    kick;
    tk(900);
    chk("trip", 1, trip);
    tk(300);
    chk("trip", 0, trip);
    chk("on", 0, drive_on);
    run_cmd <= 1'b0;
    tk(2);
    run_cmd <= 1'b1;
    tk(3);
    chk("on", 1, drive_on);
    essential_services_override <= 1'b1;
    wr(`OFS_RESTART, 32'h04B0000F);
    rc("restart", `OFS_RESTART, 32'h04B00002);
    essential_services_override <= 1'b0;
    wr(`OFS_RESTART, 32'h04B00000);
    kick;
    tk(3);
    ahb(`OFS_STATUS, 1'b0, 32'h0);
    chk("state", 3'h4, rv[7:5]);
    wr(`OFS_CTRL, 32'h8);
    power_restored <= 1'b1;
    @(posedge clk) power_restored <= 1'b0;
    tk(3);
    chk("trip", 0, trip);
    wr(`OFS_RESTART, 32'h00060001);
    fault_present <= 1'b1;
    kick;
    tk(2300);
    ahb(`OFS_STATUS, 1'b0, 32'h0);
    chk("state", 3'h2, rv[7:5]);
    chk("used", 0, rv[11:8]);
    wrap_up;
  end
endmodule

bind drive_protection_restart drive_protection_restart_chk u_chk (
  .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .current_pct(current_pct), .out_freq_hz(out_freq_hz), .run_cmd(run_cmd),
  .reverse_request(reverse_request), .supply_reversed(supply_reversed),
  .ext_trip(ext_trip), .cap_active(cap_active), .drive_on(drive_on),
  .ramp_down(ramp_down), .dir_reverse(dir_reverse), .phase_swap(phase_swap),
  .trip(trip), .thermal_trip(thermal_trip));
`default_nettype wire
